// ===== src/flrh_pkg.sv
// Purpose: Constants and carriers for the frame, low-speed and root hub registers
// Assumes: Command-coded register access, one 32-bit word per command
// Notes: Descriptor reset values are build choices, not fixed by the hardware
`default_nettype none
package flrh_pkg;
    // Command codes: read codes, write codes carry bit 7
    localparam logic [7:0] CMD_RD_FRAME = 8'h0f;
    localparam logic [7:0] CMD_RD_LIMIT = 8'h11;
    localparam logic [7:0] CMD_WR_LIMIT = 8'h91;
    localparam logic [7:0] CMD_RD_DESC_A = 8'h12;
    localparam logic [7:0] CMD_WR_DESC_A = 8'h92;
    localparam logic [7:0] CMD_WR_DESC_B = 8'h93;
    localparam logic [7:0] CMD_WR_RH_STAT = 8'h94;
    localparam logic [7:0] CMD_WR_PORT1 = 8'h95;
    localparam logic [7:0] CMD_WR_PORT2 = 8'h96;
    // Field positions of the first root hub descriptor, and the threshold MSB
    localparam int PGT_MSB = 31;
    localparam int PGT_LSB = 24;
    localparam int OC_ABSENT_BIT = 12;
    localparam int OC_PORT_BIT = 11;
    localparam int COMPOUND_BIT = 10;
    localparam int PWR_ABSENT_BIT = 9;
    localparam int PWR_PORT_BIT = 8;
    localparam int PORT_CNT_MSB = 1;
    localparam int LIMIT_MSB = 10;
    // Reset values
    localparam logic [15:0] RST_FRAME = 16'h0000;
    localparam logic [10:0] RST_LIMIT = 11'h628;
    localparam logic [7:0] RST_PGT = 8'h01;
    localparam logic RST_OC_ABSENT = 1'b0;
    localparam logic RST_PWR_ABSENT = 1'b0;
    localparam logic RST_PWR_PORT = 1'b1;
    localparam logic RST_OC_PORT = RST_PWR_PORT;
    localparam logic [1:0] PORT_COUNT = 2'h2;
    // Controller USB states
    typedef enum logic [1:0] {
        FLRH_USB_RESET = 2'h0,
        FLRH_USB_RESUME = 2'h1,
        FLRH_USB_OPER = 2'h2,
        FLRH_USB_SUSPEND = 2'h3
    } flrh_usb_state_t;
    // Command from driver software
    typedef struct packed {
        logic valid;
        logic dword;
        logic [7:0] code;
        logic [31:0] data;
    } flrh_cmd_t;
    // Read answer
    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } flrh_rsp_t;
endpackage
`default_nettype wire

// ===== src/flrh_regs.sv
// Purpose: Frame number counter, low-speed commit limit and first root hub descriptor
// Assumes: All inputs come from logic on clk; commands are one-cycle strobes
// Notes: Notes on behaviour follow
// Notes on behaviour
// - Frame count advances on each frame-remaining reload
// - Frame count wraps from ffff to zero
// - Entering operational state bumps frame count once
// - Each frame count advance raises frame-start flag
// - Threshold read 11h, write 91h, bits 10:0
// - Low-speed start only if remaining >= threshold
// - Hardware never alters the threshold itself
// - Root hub registers accept whole words only
// - Descriptor writes accepted in any state
// - Status and port writes only when operational
// - First descriptor read 12h, write 92h
// - Bit 12 set means no overcurrent reporting
// - Bit 11 picks global or per-port reporting
// - Reporting mode resets equal to switching mode
// - Compound device bit reads zero, read-only
// - Port count field reports two ports
// - Bit 8 picks ganged or per-port power
// - Bit 9 set means ports always powered
`timescale 1ns/1ps
`default_nettype none
module flrh_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire flrh_pkg::flrh_cmd_t cmd,
    output flrh_pkg::flrh_rsp_t rsp,
    input wire flrh_pkg::flrh_usb_state_t usb_state,
    input wire logic frame_reload,
    input wire logic [13:0] frame_time_left,
    input wire logic ls_req,
    output logic ls_go,
    output logic frame_start_set,
    output logic rh_desc_b_wr,
    output logic rh_status_wr,
    output logic [1:0] rh_port_wr,
    output logic [31:0] rh_wr_data,
    output logic oc_report_off,
    output logic oc_per_port,
    output logic pwr_always_on,
    output logic pwr_per_port,
    output logic [7:0] power_good_wait_time
);
    logic [15:0] frame_count_r;
    logic [15:0] frame_count_nxt;
    logic [10:0] low_speed_commit_limit_r;
    logic [7:0] pgt_r;
    logic oc_absent_r;
    logic oc_port_r;
    logic pwr_absent_r;
    logic pwr_port_r;
    logic oper_d_r;
    logic enter_oper;
    logic frame_adv;
    logic is_oper;
    logic wr_ok;
    flrh_pkg::flrh_rsp_t rsp_r;
    logic [31:0] desc_a_word;

    // Whole-word write of the given code
    function automatic logic wr_hit(input flrh_pkg::flrh_cmd_t c, input logic [7:0] code);
        wr_hit = c.valid && c.dword && (c.code == code);
    endfunction

    assign is_oper = (usb_state == flrh_pkg::FLRH_USB_OPER);
    assign enter_oper = is_oper && !oper_d_r;
    // Reload and state entry in the same cycle count as one advance
    assign frame_adv = frame_reload || enter_oper;
    assign frame_count_nxt = frame_count_r + 16'h0001;
    assign wr_ok = is_oper;

    // Previous-cycle operational flag for entry detection
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            oper_d_r <= 1'b0;
        end else begin
            oper_d_r <= is_oper;
        end
    end

    // Frame counter, wraps naturally at 16 bits
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_count_r <= flrh_pkg::RST_FRAME;
        end else if (frame_adv) begin
            frame_count_r <= frame_count_nxt;
        end
    end

    // Flag pulse for the interrupt status register, cleared over there
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_start_set <= 1'b0;
        end else begin
            frame_start_set <= frame_adv;
        end
    end

    // Threshold changes only on a software write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_speed_commit_limit_r <= flrh_pkg::RST_LIMIT;
        end else if (wr_hit(cmd, flrh_pkg::CMD_WR_LIMIT)) begin
            low_speed_commit_limit_r <= cmd.data[flrh_pkg::LIMIT_MSB:0];
        end
    end

    // Commit check; handshake output kept combinational to avoid a lost cycle
    assign ls_go = ls_req &&
        ({3'h0, frame_time_left} >= {3'h0, low_speed_commit_limit_r});

    // First descriptor writable fields, any USB state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pgt_r <= flrh_pkg::RST_PGT;
            oc_absent_r <= flrh_pkg::RST_OC_ABSENT;
            oc_port_r <= flrh_pkg::RST_OC_PORT;
            pwr_absent_r <= flrh_pkg::RST_PWR_ABSENT;
            pwr_port_r <= flrh_pkg::RST_PWR_PORT;
        end else if (wr_hit(cmd, flrh_pkg::CMD_WR_DESC_A)) begin
            pgt_r <= cmd.data[flrh_pkg::PGT_MSB:flrh_pkg::PGT_LSB];
            oc_absent_r <= cmd.data[flrh_pkg::OC_ABSENT_BIT];
            oc_port_r <= cmd.data[flrh_pkg::OC_PORT_BIT];
            pwr_absent_r <= cmd.data[flrh_pkg::PWR_ABSENT_BIT];
            pwr_port_r <= cmd.data[flrh_pkg::PWR_PORT_BIT];
        end
    end

    // Descriptor as read; compound bit and reserved bits stay zero
    always_comb begin
        desc_a_word = 32'h0000_0000;
        desc_a_word[flrh_pkg::PGT_MSB:flrh_pkg::PGT_LSB] = pgt_r;
        desc_a_word[flrh_pkg::OC_ABSENT_BIT] = oc_absent_r;
        desc_a_word[flrh_pkg::OC_PORT_BIT] = oc_port_r;
        desc_a_word[flrh_pkg::COMPOUND_BIT] = 1'b0;
        desc_a_word[flrh_pkg::PWR_ABSENT_BIT] = pwr_absent_r;
        desc_a_word[flrh_pkg::PWR_PORT_BIT] = pwr_port_r;
        desc_a_word[flrh_pkg::PORT_CNT_MSB:0] = flrh_pkg::PORT_COUNT;
    end

    // Per-port reporting only means something with reporting present
    assign oc_report_off = oc_absent_r;
    assign oc_per_port = !oc_absent_r && oc_port_r;
    assign pwr_always_on = pwr_absent_r;
    assign pwr_per_port = !pwr_absent_r && pwr_port_r;
    assign power_good_wait_time = pgt_r;

    // Read path, one cycle after the command; unknown codes read zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsp_r <= '0;
        end else begin
            rsp_r.valid <= cmd.valid && !cmd.code[7];
            rsp_r.data <= 32'h0000_0000;
            if (cmd.valid && !cmd.code[7]) begin
                unique case (cmd.code)
                    flrh_pkg::CMD_RD_FRAME: rsp_r.data <= {16'h0000, frame_count_r};
                    flrh_pkg::CMD_RD_LIMIT: begin
                        rsp_r.data <= {21'h000000, low_speed_commit_limit_r};
                    end
                    flrh_pkg::CMD_RD_DESC_A: begin
                        // Part-word access to a root hub register reads zero
                        rsp_r.data <= cmd.dword ? desc_a_word : 32'h0000_0000;
                    end
                    default: rsp_r.data <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign rsp = rsp_r;

    // Strobes toward the rest of the root hub; status writes need operational state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rh_desc_b_wr <= 1'b0;
            rh_status_wr <= 1'b0;
            rh_port_wr <= 2'h0;
            rh_wr_data <= 32'h0000_0000;
        end else begin
            rh_desc_b_wr <= wr_hit(cmd, flrh_pkg::CMD_WR_DESC_B);
            rh_status_wr <= wr_ok && wr_hit(cmd, flrh_pkg::CMD_WR_RH_STAT);
            rh_port_wr[0] <= wr_ok && wr_hit(cmd, flrh_pkg::CMD_WR_PORT1);
            rh_port_wr[1] <= wr_ok && wr_hit(cmd, flrh_pkg::CMD_WR_PORT2);
            if (cmd.valid && cmd.dword) begin
                rh_wr_data <= cmd.data;
            end
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    a_frame_reload_inc: assert property (frame_reload |=>
        frame_count_r == $past(frame_count_r) + 16'h0001)
        else $error("frame count did not advance on reload");
    a_frame_wrap: assert property ((frame_adv && frame_count_r == 16'hffff) |=>
        frame_count_r == 16'h0000)
        else $error("frame count did not wrap");
    a_oper_entry_inc: assert property ($rose(is_oper) |=>
        frame_count_r != $past(frame_count_r))
        else $error("no advance on operational entry");
    a_frame_start_flag: assert property ((frame_count_r != $past(frame_count_r)) |->
        frame_start_set)
        else $error("frame start flag missing");
    a_ls_commit_gate: assert property (ls_go |->
        frame_time_left >= {3'h0, low_speed_commit_limit_r})
        else $error("low-speed start past threshold");
    a_limit_hold: assert property (!wr_hit(cmd, flrh_pkg::CMD_WR_LIMIT) |=>
        $stable(low_speed_commit_limit_r))
        else $error("threshold changed without write");
    a_status_wr_gate: assert property ((rh_status_wr || rh_port_wr != 2'h0) |->
        $past(is_oper))
        else $error("status write outside operational");
    a_desc_wr_any: assert property (wr_hit(cmd, flrh_pkg::CMD_WR_DESC_A) |=>
        pgt_r == $past(cmd.data[31:24]))
        else $error("descriptor write lost");
    a_desc_rd_fixed: assert property ((rsp.valid && $past(cmd.code) ==
        flrh_pkg::CMD_RD_DESC_A) |-> rsp.data[10] == 1'b0 && rsp.data[23:13] == 11'h000)
        else $error("fixed descriptor bits wrong");
    a_limit_rd_high: assert property ((rsp.valid && $past(cmd.code) ==
        flrh_pkg::CMD_RD_LIMIT) |-> rsp.data[31:11] == 21'h000000)
        else $error("threshold high bits not zero");

    c_frame_wrap: cover property (frame_adv && frame_count_r == 16'hffff);
    c_ls_refused: cover property (ls_req && !ls_go);
    c_oper_entry: cover property ($rose(is_oper));
    c_status_wr: cover property (rh_status_wr);
endmodule
`default_nettype wire

// ===== tb/flrh_host.sv
// Purpose: Host driver model issuing command-coded register accesses
// Assumes: Each command is a one-cycle strobe launched just after a rising edge
// Notes: Timed waits such as power-good are left to the caller
`timescale 1ns/1ps
`default_nettype none
module flrh_host (
    input wire logic clk,
    output var flrh_pkg::flrh_cmd_t cmd
);
    initial cmd = '0;
    // Strobe for one cycle, then idle one cycle so no edge sees two commands
    task automatic issue(input logic [7:0] c, input logic [31:0] d, input logic dw);
        @(posedge clk);
        cmd <= '{valid: 1'b1, dword: dw, code: c, data: d};
        @(posedge clk);
        cmd <= '0;
    endtask
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: Self-checking bench for the frame, low-speed and root hub registers
// Assumes: Reads answer one cycle after the command is taken
// Notes: Wrap test walks the whole 16-bit frame count, about 66k cycles
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, rst_n, frame_reload, ls_req, ls_go, frame_start_set;
    logic rh_desc_b_wr, rh_status_wr, oc_report_off, oc_per_port, pwr_always_on, pwr_per_port;
    logic [13:0] frame_time_left;
    logic [1:0] rh_port_wr;
    logic [7:0] power_good_wait_time;
    logic [31:0] rh_wr_data, lf, d;
    logic [31:0] exp_q[$];
    flrh_pkg::flrh_usb_state_t usb_state;
    flrh_pkg::flrh_cmd_t cmd;
    flrh_pkg::flrh_rsp_t rsp;
    int err_count = 0;
    int checked = 0;

    flrh_host u_host (.clk(clk), .cmd(cmd));
    flrh_regs u_dut (.clk(clk), .rst_n(rst_n), .cmd(cmd), .rsp(rsp), .usb_state(usb_state),
        .frame_reload(frame_reload), .frame_time_left(frame_time_left), .ls_req(ls_req),
        .ls_go(ls_go), .frame_start_set(frame_start_set), .rh_desc_b_wr(rh_desc_b_wr),
        .rh_status_wr(rh_status_wr), .rh_port_wr(rh_port_wr), .rh_wr_data(rh_wr_data),
        .oc_report_off(oc_report_off), .oc_per_port(oc_per_port),
        .pwr_always_on(pwr_always_on), .pwr_per_port(pwr_per_port),
        .power_good_wait_time(power_good_wait_time));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask

    // Note the expected word first; the monitor compares when the answer shows
    task automatic rd(input logic [7:0] c, input logic [31:0] e, input logic dw = 1'b1);
        exp_q.push_back(e);
        u_host.issue(c, 32'h0, dw);
    endtask

    // Strobes are registered, so look just after the taking edge
    task automatic wr(input logic [7:0] c, input logic [3:0] e);
        lf = lfsr(lf);
        u_host.issue(c, lf, 1'b1);
        #1 chk("strobes", {28'h0, e}, {28'h0, rh_desc_b_wr, rh_status_wr, rh_port_wr});
        chk("write data", lf, rh_wr_data);
    endtask

    // Registers settle after the taking edge, so look a little later
    task automatic levels(input logic [11:0] e);
        #1 chk("levels", {20'h0, e}, {20'h0, oc_report_off, oc_per_port, pwr_always_on,
            pwr_per_port, power_good_wait_time});
    endtask

    task automatic end_of_test();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Answer monitor, sampled mid-cycle where outputs are settled
    always @(negedge clk) begin
        if (rsp.valid === 1'b1) begin
            chk("read", exp_q.size() > 0 ? exp_q.pop_front() : 32'hbad0_bad0, rsp.data);
        end
    end

    initial begin
        repeat (90000) @(posedge clk);
        err_count++;
        end_of_test();
    end

    initial begin
        rst_n = 1'b0;
        frame_reload = 1'b0;
        ls_req = 1'b0;
        frame_time_left = 14'h0;
        usb_state = flrh_pkg::FLRH_USB_RESET;
        lf = 32'h8;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(flrh_pkg::CMD_RD_LIMIT, 32'h628);
        rd(flrh_pkg::CMD_RD_DESC_A, 32'h0100_0902);
        rd(flrh_pkg::CMD_RD_FRAME, 32'h0);
        // Threshold written before the long frame run, reread after it
        lf = lfsr(lf) | 32'h1;
        u_host.issue(flrh_pkg::CMD_WR_LIMIT, lf, 1'b1);
        u_host.issue(flrh_pkg::CMD_WR_LIMIT, ~lf, 1'b0);
        rd(flrh_pkg::CMD_RD_LIMIT, {21'h0, lf[10:0]});
        for (int k = -1; k <= 1; k++) begin
            @(posedge clk);
            frame_time_left <= 14'(lf[10:0]) + 14'(k);
            ls_req <= 1'b1;
            #1 chk("ls gate", {31'h0, k >= 0}, {31'h0, ls_go});
        end
        @(posedge clk);
        ls_req <= 1'b0;
        #1 chk("ls idle", 32'h0, {31'h0, ls_go});
        // Frame count: reload, operational entry, then full wrap
        @(posedge clk) frame_reload <= 1'b1;
        @(posedge clk) frame_reload <= 1'b0;
        #1 chk("frame start", 32'h1, {31'h0, frame_start_set});
        rd(flrh_pkg::CMD_RD_FRAME, 32'h1);
        @(posedge clk) usb_state <= flrh_pkg::FLRH_USB_OPER;
        @(posedge clk) #1 chk("frame start", 32'h1, {31'h0, frame_start_set});
        rd(flrh_pkg::CMD_RD_FRAME, 32'h2);
        @(posedge clk) frame_reload <= 1'b1;
        repeat (65533) @(posedge clk);
        frame_reload <= 1'b0;
        rd(flrh_pkg::CMD_RD_FRAME, 32'hffff);
        @(posedge clk) frame_reload <= 1'b1;
        @(posedge clk) frame_reload <= 1'b0;
        rd(flrh_pkg::CMD_RD_FRAME, 32'h0);
        rd(flrh_pkg::CMD_RD_LIMIT, {21'h0, lf[10:0]});
        // Descriptor: all ones, then clear-then-set of per-port reporting
        u_host.issue(flrh_pkg::CMD_WR_DESC_A, 32'hffff_ffff, 1'b1);
        rd(flrh_pkg::CMD_RD_DESC_A, 32'hff00_1b02);
        rd(flrh_pkg::CMD_RD_DESC_A, 32'h0, 1'b0);
        levels(12'haff);
        d = {lf[31:24], 24'h100};
        u_host.issue(flrh_pkg::CMD_WR_DESC_A, d, 1'b1);
        levels({4'b0001, lf[31:24]});
        u_host.issue(flrh_pkg::CMD_WR_DESC_A, d | 32'h800, 1'b1);
        levels({4'b0101, lf[31:24]});
        rd(flrh_pkg::CMD_RD_DESC_A, (d | 32'h800) | 32'h2);
        // Write permission outside and inside operational state
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            usb_state <= s ? flrh_pkg::FLRH_USB_OPER : flrh_pkg::FLRH_USB_SUSPEND;
            wr(flrh_pkg::CMD_WR_DESC_B, 4'b1000);
            wr(flrh_pkg::CMD_WR_RH_STAT, {1'b0, s[0], 2'b0});
            wr(flrh_pkg::CMD_WR_PORT1, {3'b0, s[0]});
            wr(flrh_pkg::CMD_WR_PORT2, {2'b0, s[0], 1'b0});
        end
        repeat (3) @(posedge clk);
        chk("pending reads", 32'h0, 32'(exp_q.size()));
        end_of_test();
    end
endmodule
`default_nettype wire
